// File: logic/sscr_regs.sv
// Write-only 3-wire serial register bank steering two synthesizers,
// the LO buffer, baseband level and the power states.
// Assumes the serial clock runs only while chip select is low, the host
// keeps data steady around rising serial clock edges, and all status pins
// are asynchronous to mclk_i.
`timescale 1ns/10ps
`include "sscr_map.svh"

module sscr_regs
  import sscr_pkg::*;
(
  input  wire logic        mclk_i,                 // System clock
  input  wire logic        rstn_i,                 // Sync reset, low
  input  wire logic        sclk_i,                 // Serial clock
  input  wire logic        cs_n_i,                 // Chip select, low
  input  wire logic        sdi_i,                  // Serial data in
  input  wire logic        hard_power_off_n_i,     // Shutdown pin, low
  input  wire logic        if_pd_lead_i,           // IF detector leads
  input  wire logic        rf_pd_lead_i,           // RF detector leads
  input  wire logic        if_locked_i,            // IF loop acquired
  input  wire logic        rf_locked_i,            // RF loop acquired
  output logic [17:0]      rf_main_divider_o,      // RF main ratio
  output logic [12:0]      rf_reference_divider_o, // RF ref ratio
  output logic [13:0]      if_main_divider_o,      // IF main ratio
  output logic [10:0]      if_reference_divider_o, // IF ref ratio
  output logic [15:0]      operating_state_o,      // State word
  output logic [15:0]      setup_o,                // Setup word
  output logic [7:0]       factory_test_o,         // Test word
  output logic             load_o,                 // Register loaded
  output logic             serial_on_o,            // Interface alive
  output logic             core_on_o,              // Core powered
  output logic             standby_o,              // Standby active
  output logic             buffered_lo_output_o,   // LO buffer on
  output logic             buffered_lo_half_o,     // LO at half rate
  output logic             baseband_level_select_o,// Reduced level
  output logic [2:0]       if_pump_current_o,      // IF pump setting
  output logic [2:0]       rf_pump_current_o,      // RF pump setting
  output logic             if_fast_acquire_o,      // IF pump at max
  output logic             rf_fast_acquire_o       // RF pump at max
);

  // ---------------- Serial clock domain ----------------
  logic                        fresh_ff;
  logic [`SSCR_FRAME_BITS-1:0] shift_ff;
  logic [`SSCR_CNT_W-1:0]      cnt_ff;
  logic [`SSCR_CNT_W-1:0]      nxt_cnt;

  // First edge of a frame restarts the bit count; select high re-arms it
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fresh_ff <= 1'b1;
    end else begin
      fresh_ff <= 1'b0;
    end
  end

  always_comb begin
    if (fresh_ff) begin
      nxt_cnt = `SSCR_CNT_W'(1);
    end else if (cnt_ff == `SSCR_CNT_MAX) begin
      nxt_cnt = cnt_ff;
    end else begin
      nxt_cnt = cnt_ff + `SSCR_CNT_W'(1);
    end
  end

  always_ff @(posedge sclk_i) begin
    if (!cs_n_i) begin
      shift_ff <= {shift_ff[`SSCR_FRAME_BITS-2:0], sdi_i};
      cnt_ff   <= nxt_cnt;
    end
  end

  // ---------------- Pin synchroniser ----------------
  logic [`SSCR_PINS-1:0] pin_s1_ff;
  logic [`SSCR_PINS-1:0] pin_s2_ff;
  logic [`SSCR_PINS-1:0] pin_s3_ff;
  logic [`SSCR_PINS-1:0] pin_ff;
  logic [`SSCR_PINS-1:0] pin_prev_ff;
  logic [`SSCR_PINS-1:0] pin_raw;

  assign pin_raw = {rf_locked_i, if_locked_i, rf_pd_lead_i, if_pd_lead_i,
                    hard_power_off_n_i, cs_n_i};

  always_ff @(posedge mclk_i) begin
    pin_s1_ff <= pin_raw;
    pin_s2_ff <= pin_s1_ff;
    pin_s3_ff <= pin_s2_ff;
  end

  // A pin change counts once the second and third stage agree
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      // Settled pin levels, so no false edge follows reset
      pin_ff      <= pin_s3_ff;
      pin_prev_ff <= pin_s3_ff;
    end else begin
      for (int i = 0; i < `SSCR_PINS; i++) begin
        if (pin_s2_ff[i] == pin_s3_ff[i]) begin
          pin_ff[i] <= pin_s3_ff[i];
        end
      end
      pin_prev_ff <= pin_ff;
    end
  end

  logic hard_on;
  logic cs_rise;
  assign hard_on = pin_ff[`SSCR_PIN_HARD];
  assign cs_rise = pin_ff[`SSCR_PIN_CS] & ~pin_prev_ff[`SSCR_PIN_CS];

  // ---------------- Frame capture ----------------
  // Shift register and count are frozen while select is high, so they are
  // stable long before the synchronised rising edge reaches this point.
  logic                       frame_ok;
  logic [`SSCR_ADDR_BITS-1:0] frame_addr;
  logic [`SSCR_DATA_BITS-1:0] frame_data;
  logic                       wr_rf_main;
  logic                       wr_rf_ref;
  logic                       wr_if_main;
  logic                       wr_if_ref;
  logic                       wr_op;
  logic                       wr_setup;
  logic                       wr_test;
  logic                       soft_wipe;

  assign frame_ok   = cs_rise & hard_on & (cnt_ff == `SSCR_CNT_FULL);
  assign frame_addr = shift_ff[`SSCR_ADDR_BITS-1:0];
  assign frame_data = shift_ff[`SSCR_FRAME_BITS-1:`SSCR_ADDR_BITS];

  // Only assigned codes load; any other frame falls through untouched
  assign wr_rf_main = frame_ok & (frame_addr == SSCR_RF_MAIN);
  assign wr_rf_ref  = frame_ok & (frame_addr == SSCR_RF_REF);
  assign wr_if_main = frame_ok & (frame_addr == SSCR_IF_MAIN);
  assign wr_if_ref  = frame_ok & (frame_addr == SSCR_IF_REF);
  assign wr_op      = frame_ok & (frame_addr == SSCR_OPSTATE);
  assign wr_setup   = frame_ok & (frame_addr == SSCR_SETUP);
  assign wr_test    = frame_ok & (frame_addr == SSCR_TEST);
  assign soft_wipe  = wr_op & ~frame_data[`SSCR_OP_SOFT_ON];

  // ---------------- Registers ----------------
  logic [`SSCR_W_RF_MAIN-1:0] rf_main_ff;
  logic [`SSCR_W_RF_REF-1:0]  rf_ref_ff;
  logic [`SSCR_W_IF_MAIN-1:0] if_main_ff;
  logic [`SSCR_W_IF_REF-1:0]  if_ref_ff;
  logic [`SSCR_W_OPSTATE-1:0] op_ff;
  logic [`SSCR_W_SETUP-1:0]   setup_ff;
  logic [`SSCR_W_TEST-1:0]    test_ff;

  // Shutdown by pin drops all programming, soft bit all but the state word, back to defaults
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !hard_on || soft_wipe) begin
      rf_main_ff <= `SSCR_DEF_RF_MAIN;
      rf_ref_ff  <= `SSCR_DEF_RF_REF;
      if_main_ff <= `SSCR_DEF_IF_MAIN;
      if_ref_ff  <= `SSCR_DEF_IF_REF;
      setup_ff   <= `SSCR_DEF_SETUP;
      test_ff    <= `SSCR_DEF_TEST;
    end else begin
      // Don't-care payload bits are simply not stored
      if (wr_rf_main) begin
        rf_main_ff <= frame_data[`SSCR_W_RF_MAIN-1:0];
      end
      if (wr_rf_ref) begin
        rf_ref_ff <= frame_data[`SSCR_W_RF_REF-1:0];
      end
      if (wr_if_main) begin
        if_main_ff <= frame_data[`SSCR_W_IF_MAIN-1:0];
      end
      if (wr_if_ref) begin
        if_ref_ff <= frame_data[`SSCR_W_IF_REF-1:0];
      end
      if (wr_setup) begin
        setup_ff <= frame_data[`SSCR_W_SETUP-1:0];
      end
      if (wr_test) begin
        test_ff <= frame_data[`SSCR_W_TEST-1:0];
      end
    end
  end

  // The state word survives soft off so the serial bus can wake the part
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !hard_on) begin
      op_ff <= `SSCR_DEF_OPSTATE;
    end else if (wr_op) begin
      op_ff <= frame_data[`SSCR_W_OPSTATE-1:0];
    end
  end

  // Registered load event, seen in the same cycle as the register changes
  logic                       wr_ff;
  logic [`SSCR_ADDR_BITS-1:0] wr_addr_ff;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wr_ff      <= 1'b0;
      wr_addr_ff <= `SSCR_ADDR_BITS'(0);
    end else begin
      wr_ff      <= frame_ok & (wr_rf_main | wr_rf_ref | wr_if_main |
                                wr_if_ref | wr_op | wr_setup | wr_test);
      wr_addr_ff <= frame_addr;
    end
  end

  // ---------------- Power state ----------------
  logic core_on;
  logic soft_on;
  logic standby_n_n;
  assign soft_on = op_ff[`SSCR_OP_SOFT_ON];
  assign standby_n_n  = op_ff[`SSCR_OP_STANDBY_N];
  assign core_on = hard_on & soft_on & standby_n_n;

  // ---------------- Turbo control, one per loop ----------------
  // Index 0 is the IF loop, index 1 the RF loop
  sscr_turbo_e turbo_ff [2];
  logic [1:0]  turbo_en;
  logic [1:0]  turbo_arm;
  logic [1:0]  flip;
  logic [1:0]  locked;

  assign turbo_en[0] = setup_ff[`SSCR_SU_IF_TURBO];
  assign turbo_en[1] = setup_ff[`SSCR_SU_RF_TURBO];
  assign flip[0]     = pin_ff[`SSCR_PIN_IF_LEAD] ^
                       pin_prev_ff[`SSCR_PIN_IF_LEAD];
  assign flip[1]     = pin_ff[`SSCR_PIN_RF_LEAD] ^
                       pin_prev_ff[`SSCR_PIN_RF_LEAD];
  assign locked[0]   = pin_ff[`SSCR_PIN_IF_LOCK];
  assign locked[1]   = pin_ff[`SSCR_PIN_RF_LOCK];

  // A new divider, a setup write or a state word write starts an acquisition
  assign turbo_arm[0] = (wr_ff & (wr_addr_ff == SSCR_IF_MAIN ||
                                  wr_addr_ff == SSCR_IF_REF ||
                                  wr_addr_ff == SSCR_SETUP ||
                                  wr_addr_ff == SSCR_OPSTATE));
  assign turbo_arm[1] = (wr_ff & (wr_addr_ff == SSCR_RF_MAIN ||
                                  wr_addr_ff == SSCR_RF_REF ||
                                  wr_addr_ff == SSCR_SETUP ||
                                  wr_addr_ff == SSCR_OPSTATE));

  for (genvar g = 0; g < 2; g++) begin : g_turbo
    always_ff @(posedge mclk_i) begin
      if (!rstn_i || !core_on || !turbo_en[g]) begin
        turbo_ff[g] <= SSCR_TB_IDLE;
      end else if (turbo_arm[g]) begin
        turbo_ff[g] <= SSCR_TB_FAST;
      end else begin
        case (turbo_ff[g])
          SSCR_TB_IDLE: begin
            turbo_ff[g] <= SSCR_TB_IDLE;
          end
          SSCR_TB_FAST: begin
            if (locked[g]) begin
              turbo_ff[g] <= SSCR_TB_IDLE;
            end else if (flip[g]) begin
              turbo_ff[g] <= SSCR_TB_ONE_FLIP;
            end
          end
          SSCR_TB_ONE_FLIP: begin
            if (locked[g] || flip[g]) begin
              turbo_ff[g] <= SSCR_TB_IDLE;
            end
          end
          default: begin
            turbo_ff[g] <= SSCR_TB_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------- Outputs ----------------
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      serial_on_o             <= 1'b0;
      core_on_o               <= 1'b0;
      standby_o               <= 1'b0;
      buffered_lo_output_o    <= 1'b0;
      buffered_lo_half_o      <= 1'b0;
      baseband_level_select_o <= 1'b0;
      load_o                  <= 1'b0;
    end else begin
      serial_on_o             <= hard_on;
      core_on_o               <= core_on;
      standby_o               <= hard_on & soft_on & ~standby_n_n;
      buffered_lo_output_o    <= core_on & op_ff[`SSCR_OP_LO_EN];
      buffered_lo_half_o      <= op_ff[`SSCR_OP_LO_HALF];
      baseband_level_select_o <= setup_ff[`SSCR_SU_BB_LEVEL];
      load_o                  <= wr_ff;
    end
  end

  // Turbo drives its own flags; the pump outputs always follow the setup word
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      if_fast_acquire_o <= 1'b0;
      rf_fast_acquire_o <= 1'b0;
      if_pump_current_o <= `SSCR_PUMP_W'(0);
      rf_pump_current_o <= `SSCR_PUMP_W'(0);
    end else begin
      if_fast_acquire_o <= (turbo_ff[0] != SSCR_TB_IDLE);
      rf_fast_acquire_o <= (turbo_ff[1] != SSCR_TB_IDLE);
      if_pump_current_o <= setup_ff[`SSCR_SU_IF_PUMP];
      rf_pump_current_o <= setup_ff[`SSCR_SU_RF_PUMP];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rf_main_divider_o      <= `SSCR_DEF_RF_MAIN;
      rf_reference_divider_o <= `SSCR_DEF_RF_REF;
      if_main_divider_o      <= `SSCR_DEF_IF_MAIN;
      if_reference_divider_o <= `SSCR_DEF_IF_REF;
      operating_state_o      <= `SSCR_DEF_OPSTATE;
      setup_o                <= `SSCR_DEF_SETUP;
      factory_test_o         <= `SSCR_DEF_TEST;
    end else begin
      rf_main_divider_o      <= rf_main_ff;
      rf_reference_divider_o <= rf_ref_ff;
      if_main_divider_o      <= if_main_ff;
      if_reference_divider_o <= if_ref_ff;
      operating_state_o      <= op_ff;
      setup_o                <= setup_ff;
      factory_test_o         <= test_ff;
    end
  end

endmodule

// File: logic/sscr_map.svh
// Constants of the serial synthesizer control register bank.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SSCR_MAP_SVH
`define SSCR_MAP_SVH

// Frame layout
`define SSCR_FRAME_BITS   24
`define SSCR_ADDR_BITS    4
`define SSCR_DATA_BITS    20
`define SSCR_CNT_W        5
`define SSCR_CNT_FULL     5'h18
`define SSCR_CNT_MAX      5'h1f

// Address codes
`define SSCR_ADDR_RF_MAIN 4'h0
`define SSCR_ADDR_RF_REF  4'h1
`define SSCR_ADDR_IF_MAIN 4'h2
`define SSCR_ADDR_IF_REF  4'h3
`define SSCR_ADDR_OPSTATE 4'h4
`define SSCR_ADDR_SETUP   4'h5
`define SSCR_ADDR_TEST    4'h7

// Used payload widths
`define SSCR_W_RF_MAIN    18
`define SSCR_W_RF_REF     13
`define SSCR_W_IF_MAIN    14
`define SSCR_W_IF_REF     11
`define SSCR_W_OPSTATE    16
`define SSCR_W_SETUP      16
`define SSCR_W_TEST       8

// Power-up defaults
`define SSCR_DEF_RF_MAIN  18'h2a037
`define SSCR_DEF_RF_REF   13'h07b0
`define SSCR_DEF_IF_MAIN  14'h1977
`define SSCR_DEF_IF_REF   11'h1ec
`define SSCR_DEF_OPSTATE  16'h892f
`define SSCR_DEF_SETUP    16'hd03f
`define SSCR_DEF_TEST     8'h00

// Operating state fields
`define SSCR_OP_SOFT_ON   0
`define SSCR_OP_STANDBY_N 1
`define SSCR_OP_LO_EN     3
`define SSCR_OP_LO_HALF   4

// Setup fields
`define SSCR_SU_IF_TURBO  15
`define SSCR_SU_RF_TURBO  14
`define SSCR_SU_BB_LEVEL  13
`define SSCR_SU_RF_PUMP   5:3
`define SSCR_SU_IF_PUMP   2:0
`define SSCR_PUMP_W       3

// Pin synchroniser
`define SSCR_PINS         6
`define SSCR_PIN_CS       0
`define SSCR_PIN_HARD     1
`define SSCR_PIN_IF_LEAD  2
`define SSCR_PIN_RF_LEAD  3
`define SSCR_PIN_IF_LOCK  4
`define SSCR_PIN_RF_LOCK  5

`endif

// File: logic/sscr_pkg.sv
// Types of the serial synthesizer control register bank.
// Assumes sscr_map.svh is on the include path.
`include "sscr_map.svh"

package sscr_pkg;

  typedef enum logic [3:0] {
    SSCR_RF_MAIN = `SSCR_ADDR_RF_MAIN,
    SSCR_RF_REF  = `SSCR_ADDR_RF_REF,
    SSCR_IF_MAIN = `SSCR_ADDR_IF_MAIN,
    SSCR_IF_REF  = `SSCR_ADDR_IF_REF,
    SSCR_OPSTATE = `SSCR_ADDR_OPSTATE,
    SSCR_SETUP   = `SSCR_ADDR_SETUP,
    SSCR_TEST    = `SSCR_ADDR_TEST
  } sscr_addr_e;

  typedef enum logic [2:0] {
    SSCR_TB_IDLE     = 3'b001,
    SSCR_TB_FAST     = 3'b010,
    SSCR_TB_ONE_FLIP = 3'b100
  } sscr_turbo_e;

endpackage

// File: verification/sscr_host.sv
// Host model: bit-bangs frames onto the 3-wire link.
// Assumes the bench calls send and waits for it to return.
`timescale 1ns/10ps
module sscr_host (
  output logic sclk_o, // Link clock
  output logic cs_n_o, // Select, low
  output logic sdi_o   // Data
);
  // A select rise at start arms the device's bit counter
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    sdi_o  = 1'b0;
    #1 cs_n_o = 1'b1;
  end

  // Link clock idles low; data flips once released
  task automatic send(input logic [23:0] w, input int n, input int hold);
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = (i < 24) ? w[i] : 1'b0;
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    sdi_o = ~sdi_o;
    #(64 + hold) cs_n_o = 1'b1;
    #200;
  endtask
endmodule

// File: verification/sscr_regs_chk_asserts.sv
// Checker: timing relations at the register bank's ports.
// Assumes it is bound onto sscr_regs; constants from sscr_map.svh.
`timescale 1ns/10ps
`include "sscr_map.svh"
module sscr_regs_chk (
  input wire logic        mclk_i,                  // Clock
  input wire logic        rstn_i,                  // Reset, low
  input wire logic        cs_n_i,                  // Select, low
  input wire logic        hard_power_off_n_i,      // Pin, low
  input wire logic        if_locked_i,             // IF lock
  input wire logic [17:0] rf_main_divider_o,       // RF main
  input wire logic [15:0] operating_state_o,       // State word
  input wire logic [15:0] setup_o,                 // Setup word
  input wire logic        load_o,                  // Load pulse
  input wire logic        serial_on_o,             // Link alive
  input wire logic        core_on_o,               // Core on
  input wire logic        standby_o,               // Standby
  input wire logic        buffered_lo_output_o,    // LO on
  input wire logic        buffered_lo_half_o,      // LO half
  input wire logic        baseband_level_select_o, // Low level
  input wire logic [2:0]  if_pump_current_o,       // IF pump
  input wire logic        if_fast_acquire_o,       // IF turbo
  input wire logic        rf_fast_acquire_o        // RF turbo
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_load_single: assert property (load_o |=> !load_o)
    else $error("load pulse longer than one cycle");
  a_load_after_cs: assert property (load_o |->
    cs_n_i && $past(cs_n_i, 3))
    else $error("load without a closed frame");
  a_core_state: assert property (core_on_o |-> serial_on_o &&
    operating_state_o[`SSCR_OP_SOFT_ON] &&
    operating_state_o[`SSCR_OP_STANDBY_N])
    else $error("core on against state word");
  a_standby_state: assert property (standby_o |-> !core_on_o &&
    !operating_state_o[`SSCR_OP_STANDBY_N])
    else $error("standby against state word");
  a_lo_enable: assert property (buffered_lo_output_o |-> core_on_o &&
    operating_state_o[`SSCR_OP_LO_EN])
    else $error("LO buffer on while disabled");
  a_lo_half: assert property ($past(rstn_i) |->
    buffered_lo_half_o == operating_state_o[`SSCR_OP_LO_HALF])
    else $error("LO half flag differs from state word");
  a_bb_level: assert property ($past(rstn_i) |->
    baseband_level_select_o == setup_o[`SSCR_SU_BB_LEVEL])
    else $error("baseband level differs from setup");
  a_pump_field: assert property ($past(rstn_i) |->
    if_pump_current_o == setup_o[`SSCR_SU_IF_PUMP])
    else $error("IF pump differs from setup");
  a_turbo_start: assert property ($rose(rf_fast_acquire_o) |->
    $past(load_o) && setup_o[`SSCR_SU_RF_TURBO])
    else $error("RF turbo started without load");
  a_turbo_lock: assert property ($rose(if_locked_i) |->
    ##[1:6] !if_fast_acquire_o)
    else $error("IF turbo kept after lock");
  a_pin_off: assert property ($fell(hard_power_off_n_i) |->
    ##[1:6] !serial_on_o)
    else $error("link alive after pin low");
  a_off_defaults: assert property (!serial_on_o && !$past(serial_on_o) |->
    setup_o == `SSCR_DEF_SETUP && rf_main_divider_o == `SSCR_DEF_RF_MAIN)
    else $error("registers kept through pin shutdown");

  c_load: cover property (load_o);
  c_turbo_end: cover property ($fell(rf_fast_acquire_o));
  c_standby: cover property (standby_o);
  c_pin_off: cover property (!serial_on_o);
endmodule

bind sscr_regs sscr_regs_chk u_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
  .hard_power_off_n_i(hard_power_off_n_i), .if_locked_i(if_locked_i),
  .rf_main_divider_o(rf_main_divider_o), .setup_o(setup_o),
  .operating_state_o(operating_state_o), .load_o(load_o),
  .serial_on_o(serial_on_o), .core_on_o(core_on_o), .standby_o(standby_o),
  .buffered_lo_output_o(buffered_lo_output_o),
  .buffered_lo_half_o(buffered_lo_half_o),
  .baseband_level_select_o(baseband_level_select_o),
  .if_pump_current_o(if_pump_current_o),
  .if_fast_acquire_o(if_fast_acquire_o), .rf_fast_acquire_o(rf_fast_acquire_o)
);

// File: verification/sscr_regs_test.sv
// Testbench for the serial register bank.
// Assumes sscr_host drives the link and the checker is bound in.
`timescale 1ns/10ps
`include "sscr_map.svh"
module sscr_regs_test
  import sscr_pkg::*;
;
  localparam logic [19:0] PAY = 20'hcb6e3;
  logic        mclk_i  = 1'b0;
  logic        rstn_i  = 1'b0;
  logic        hard_n  = 1'b1;
  logic        if_lead = 1'b0;
  logic        rf_lead = 1'b0;
  logic        if_lock = 1'b0;
  logic        rf_lock = 1'b0;
  logic        sclk_i, cs_n_i, sdi_i;
  logic [17:0] rf_main;
  logic [12:0] rf_ref;
  logic [13:0] if_main;
  logic [10:0] if_ref;
  logic [15:0] op, setup;
  logic [7:0]  test_w;
  logic        load, ser_on, core_on, standby_n, lo_on, lo_half, bb;
  logic [2:0]  if_pump, rf_pump;
  logic        if_fast, rf_fast;
  int          mismatches = 0;
  int          n_tests = 0;
  int          n_loads = 0;

  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (load === 1'b1) n_loads <= n_loads + 1;

  sscr_regs u_dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .sdi_i(sdi_i), .hard_power_off_n_i(hard_n), .if_pd_lead_i(if_lead),
    .rf_pd_lead_i(rf_lead), .if_locked_i(if_lock), .rf_locked_i(rf_lock),
    .rf_main_divider_o(rf_main), .rf_reference_divider_o(rf_ref),
    .if_main_divider_o(if_main), .if_reference_divider_o(if_ref),
    .operating_state_o(op), .setup_o(setup), .factory_test_o(test_w),
    .load_o(load), .serial_on_o(ser_on), .core_on_o(core_on),
    .standby_o(standby_n), .buffered_lo_output_o(lo_on),
    .buffered_lo_half_o(lo_half), .baseband_level_select_o(bb),
    .if_pump_current_o(if_pump), .rf_pump_current_o(rf_pump),
    .if_fast_acquire_o(if_fast), .rf_fast_acquire_o(rf_fast)
  );
  sscr_host u_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i));

  task automatic chk(input string nm, input logic [23:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [19:0] p);
    u_host.send({p, a}, 24, 0);
    tick(1);
  endtask

  task automatic t_defaults;
    chk("rf_main", `SSCR_DEF_RF_MAIN, rf_main);
    chk("rf_ref", `SSCR_DEF_RF_REF, rf_ref);
    chk("if_main", `SSCR_DEF_IF_MAIN, if_main);
    chk("if_ref", `SSCR_DEF_IF_REF, if_ref);
    chk("op", `SSCR_DEF_OPSTATE, op);
    chk("setup", `SSCR_DEF_SETUP, setup);
    chk("test", `SSCR_DEF_TEST, test_w);
    chk("core_on", 1'b1, core_on);
  endtask

  task automatic t_regs;
    int l;
    for (int i = 0; i < 7; i++) begin
      l = n_loads;
      wr(sscr_addr_e'(i == 6 ? 7 : i), PAY);
      chk("loads", l + 1, n_loads);
    end
    chk("rf_main", PAY[17:0], rf_main);
    chk("rf_ref", PAY[12:0], rf_ref);
    chk("if_main", PAY[13:0], if_main);
    chk("if_ref", PAY[10:0], if_ref);
    chk("op", PAY[15:0], op);
    chk("setup", PAY[15:0], setup);
    chk("test", PAY[7:0], test_w);
    chk("bb", PAY[13], bb);
    chk("if_pump", PAY[2:0], if_pump);
    chk("rf_pump", PAY[5:3], rf_pump);
    chk("lo_on", PAY[3], lo_on);
  endtask

  task automatic t_refuse;
    int l;
    l = n_loads;
    wr(4'h6, 20'h00000);
    for (int a = 8; a < 16; a++) wr(4'(a), 20'h00000);
    u_host.send(24'h000000, 23, 0);
    u_host.send(24'h000000, 25, 500);
    tick(2);
    chk("loads", l, n_loads);
    chk("rf_main", PAY[17:0], rf_main);
    chk("setup", PAY[15:0], setup);
  endtask

  task automatic t_lo;
    wr(SSCR_OPSTATE, 20'h0001b);
    chk("lo_on", 1'b1, lo_on);
    chk("lo_half", 1'b1, lo_half);
    wr(SSCR_OPSTATE, 20'h0000b);
    chk("lo_half", 1'b0, lo_half);
  endtask

  task automatic t_turbo;
    wr(SSCR_SETUP, 20'h0c03f);
    chk("if_fast", 1'b1, if_fast);
    chk("rf_fast", 1'b1, rf_fast);
    rf_lead = 1'b1;
    tick(10);
    chk("rf_fast", 1'b1, rf_fast);
    rf_lead = 1'b0;
    tick(10);
    chk("rf_fast", 1'b0, rf_fast);
    chk("rf_pump", 3'h7, rf_pump);
    if_lock = 1'b1;
    tick(10);
    chk("if_fast", 1'b0, if_fast);
    if_lock = 1'b0;
    wr(SSCR_SETUP, 20'h0c03f);
    chk("if_fast", 1'b1, if_fast);
    chk("rf_fast", 1'b1, rf_fast);
    rf_lock = 1'b1;
    if_lead = 1'b1;
    tick(10);
    chk("rf_fast", 1'b0, rf_fast);
    chk("if_fast", 1'b1, if_fast);
    if_lead = 1'b0;
    tick(10);
    chk("if_fast", 1'b0, if_fast);
    rf_lock = 1'b0;
  endtask

  task automatic t_power;
    int l;
    wr(SSCR_RF_MAIN, 20'h12345);
    wr(SSCR_OPSTATE, 20'h00009);
    chk("standby", 1'b1, standby_n);
    chk("core_on", 1'b0, core_on);
    chk("rf_main", 18'h12345, rf_main);
    wr(SSCR_OPSTATE, 20'h0000a);
    chk("core_on", 1'b0, core_on);
    chk("serial_on", 1'b1, ser_on);
    chk("rf_main", `SSCR_DEF_RF_MAIN, rf_main);
    wr(SSCR_OPSTATE, 20'h00003);
    chk("core_on", 1'b1, core_on);
    hard_n = 1'b0;
    tick(10);
    chk("serial_on", 1'b0, ser_on);
    l = n_loads;
    wr(SSCR_RF_MAIN, 20'h12345);
    chk("loads", l, n_loads);
    hard_n = 1'b1;
    tick(10);
    chk("rf_main", `SSCR_DEF_RF_MAIN, rf_main);
    chk("op", `SSCR_DEF_OPSTATE, op);
  endtask

  task automatic summarize;
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    tick(5);
    rstn_i = 1'b1;
    tick(6);
    t_defaults;
    t_regs;
    t_refuse;
    t_lo;
    t_turbo;
    t_power;
    summarize;
  end

  // About four times the expected run length
  initial begin
    #200000;
    mismatches++;
    summarize;
  end
endmodule
